/* File: hdl/tml_mem.sv */
/*
 page memory, lock logic and configuration of a contactless tag.
 assumes: page commands come from protocol logic on I_CLK, one-cycle
 I_REQ; session state and the idle-entry pulse are on the same clock.
*/
// Functional notes
// - identifier and check bytes fill nine bytes
// - check bytes are xor of serial bytes, the first also with the cascade tag
// - identifier and internal byte never writable
// - random mode in active masks identifier, signature
// - identifier mode switch needs unfrozen, traceable/authenticated
// - random identifier four bytes plus xor check
// - ATQA follows mode, SAK fixed; new value at idle
// - low lock bits make pages read-only
// - block bits freeze groups of lock bits
// - page two write ors lock bytes only
// - locks reset zero, act at once
// - lock and one-time writes commit atomically
// - high lock bits guard page pairs, set-only
// - high locks reset zero, top byte reads zero
// - one-time page ors in data, resets zero
// - user area readable and writable
// - configuration and key pages at fixed addresses
// - random and secure-messaging enables in bits 0,1
// - protection start page in bits 6..0
// - counter byte bit layout
// - failure limit split over two bytes
// - key-lock bits freeze keys, set-only
// - write to frozen element answered with nak; frozen lock bits in a page two write are dropped and the write is acked
// - protection from start page, applied at idle
// - random enable change needs new power cycle
`timescale 1ns/1ps
`default_nettype none
`include "tml_consts.svh"
module tml_mem #(
   // factory identifier bytes sn6..sn0, value is arbitrary
   parameter logic [55:0] P_UID = 56'h0123456789ABC5,
   // internal byte of page 2, value is arbitrary
   parameter logic [7:0] P_INTERNAL = 8'h5A
) (
   input wire logic I_CLK,
   input wire logic I_RST_B,
   input wire logic I_REQ,
   input wire tml_pkg::tml_req_t I_CMD,
   input wire tml_pkg::tml_ses_t I_SESSION,
   input wire logic I_IDLE_ENTRY,
   input wire logic [31:0] I_RAND_ID,
   output logic O_ACK,
   output logic O_NAK,
   output logic [31:0] O_RDATA,
   output logic O_SIG_MASK,
   output logic O_RID_ACTIVE,
   output logic [55:0] O_ANTICOL_ID,
   output logic [15:0] O_ANTICOL_BCC,
   output logic [15:0] O_ATQA,
   output logic [7:0] O_SAK,
   output logic O_SEC_MSG,
   output logic O_CNT_INC_OPEN,
   output logic O_CNT_RD_OPEN,
   output logic O_READ_RESTRICT,
   output logic [7:0] O_READ_RESTRICT_SELECT_START,
   output logic [7:0] O_VIRT_TYPE,
   output logic [9:0] O_FAIL_LIMIT,
   output logic [127:0] O_DATA_KEY,
   output logic [127:0] O_RETR_KEY
);
   tml_pkg::tml_st_t s_r; // registered state
   tml_pkg::tml_st_t s_nxt; // next state
   tml_pkg::tml_pcls_t pcls; // region of the addressed page
   logic [7:0] pg; // addressed page
   logic [5:0] idx; // memory index
   logic [31:0] cur; // current page contents
   logic [31:0] wd; // write data
   logic [31:0] nw; // new page value
   logic [15:0] frz; // frozen low lock bits
   logic read_restrict_select_hit; // page inside protected segment
   logic [3:0] unit; // high lock unit of a data page

   // check byte helpers
   localparam logic [7:0] BCC0 = `TML_CT ^ P_UID[7:0] ^ P_UID[15:8]
      ^ P_UID[23:16];
   localparam logic [7:0] BCC1 = P_UID[31:24] ^ P_UID[39:32]
      ^ P_UID[47:40] ^ P_UID[55:48];

   // factory image: identifier, checks, internal byte, defaults
   function automatic logic [59:0][31:0] mem_init();
      logic [59:0][31:0] m;
      m = '0;
      m[0] = {BCC0, P_UID[23:0]};
      m[1] = P_UID[55:24];
      m[2] = {16'h0000, P_INTERNAL, BCC1};
      m[41][31:24] = `TML_READ_RESTRICT_SELECT_START_RST;
      m[42][15:8] = `TML_VIRTUAL_CARD_TYPE_RST;
      return m;
   endfunction : mem_init

   // page classification
   always_comb
   begin
      pg = I_CMD.page;
      idx = pg[5:0];
      unit = 4'(pg[5:1] - 5'h08);
      if (pg < `TML_PG_LOCKLO)
         pcls = tml_pkg::PC_UID;
      else if (pg == `TML_PG_LOCKLO)
         pcls = tml_pkg::PC_LOCKLO;
      else if (pg == `TML_PG_OTP)
         pcls = tml_pkg::PC_OTP;
      else if (pg <= `TML_PG_LOWDATA_LAST)
         pcls = tml_pkg::PC_LOWDATA;
      else if (pg <= `TML_PG_USER_LAST)
         pcls = tml_pkg::PC_HIDATA;
      else if (pg == `TML_PG_LOCKHI)
         pcls = tml_pkg::PC_LOCKHI;
      else if (pg == `TML_PG_CFG0 || pg == `TML_PG_CFG1)
         pcls = tml_pkg::PC_CFG;
      else if (pg == `TML_PG_KEYLOCK)
         pcls = tml_pkg::PC_KEYLOCK;
      else if (pg >= `TML_PG_KEY0 && pg <= `TML_PG_KEY0_LAST)
         pcls = tml_pkg::PC_KEY0;
      else if (pg >= `TML_PG_KEY1 && pg <= `TML_PG_KEY1_LAST)
         pcls = tml_pkg::PC_KEY1;
      else if (pg <= `TML_PG_LAST)
         pcls = tml_pkg::PC_RFU;
      else
         pcls = tml_pkg::PC_BAD;
   end

   // next state: commands, idle-entry load, anticollision values
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.ack = 1'b0;
      s_nxt.nak = 1'b0;
      cur = s_r.mem[idx];
      wd = I_CMD.wdata;
      nw = cur;
      // block bits freeze groups of lock bits
      frz = {{6{s_r.mem[2][18]}}, {6{s_r.mem[2][17]}},
         s_r.mem[2][16], 3'b000};
      // segment from start page, disabled above last page
      read_restrict_select_hit = (s_r.read_restrict_select_start <= `TML_PG_LAST)
         && (pg >= s_r.read_restrict_select_start)
         && (I_SESSION != tml_pkg::TML_SES_AUTH);
      // settings and random value only change on idle entry
      if (I_IDLE_ENTRY)
      begin
         s_nxt.random_ident_enable = s_r.mem[41][`TML_RID_BIT];
         // bit 7 of the start byte is unused and never reaches the field
         s_nxt.read_restrict_select_start = {1'b0, s_r.mem[41][30:24]};
         s_nxt.rd_restrict = s_r.mem[42][`TML_READ_RESTRICT_SELECT_BIT];
         s_nxt.rid_val = I_RAND_ID;
      end
      if (I_REQ && !I_CMD.wr)
      begin
         // page read
         s_nxt.ack = 1'b1;
         s_nxt.rdata = cur;
         if (read_restrict_select_hit && s_r.rd_restrict)
         begin
            s_nxt.ack = 1'b0;
            s_nxt.nak = 1'b1;
            s_nxt.rdata = '0;
         end
         else
         begin
            unique case (pcls)
               tml_pkg::PC_UID, tml_pkg::PC_LOCKLO:
                  // masked in random mode until identity retrieved
                  if (s_r.random_ident_enable
                     && I_SESSION == tml_pkg::TML_SES_ACTIVE)
                     s_nxt.rdata = '0;
               tml_pkg::PC_LOCKHI:
                  s_nxt.rdata = {8'h00, cur[23:0]};
               tml_pkg::PC_KEY0, tml_pkg::PC_KEY1:
                  s_nxt.rdata = '0; // keys are write-only
               tml_pkg::PC_BAD:
               begin
                  s_nxt.ack = 1'b0;
                  s_nxt.nak = 1'b1;
                  s_nxt.rdata = '0;
               end
               tml_pkg::PC_OTP, tml_pkg::PC_LOWDATA,
               tml_pkg::PC_HIDATA, tml_pkg::PC_CFG,
               tml_pkg::PC_KEYLOCK, tml_pkg::PC_RFU:
                  s_nxt.rdata = cur;
            endcase
         end
      end
      else if (I_REQ)
      begin
         // page write: whole page commits in one edge, tear-safe
         s_nxt.ack = 1'b1;
         unique case (pcls)
            tml_pkg::PC_UID:
               s_nxt.ack = 1'b0;
            tml_pkg::PC_LOCKLO:
               // bytes 0,1 kept, lock bytes or'ed minus frozen bits
               nw = {cur[31:16] | (wd[31:16] & ~frz),
                  cur[15:0]};
            tml_pkg::PC_OTP:
               if (s_r.mem[2][19])
                  s_nxt.ack = 1'b0;
               else
                  nw = cur | wd;
            tml_pkg::PC_LOWDATA:
               if (s_r.mem[2][{1'b1, pg[3:0]}])
                  s_nxt.ack = 1'b0;
               else
                  nw = wd;
            tml_pkg::PC_HIDATA:
               if (s_r.mem[40][unit])
                  s_nxt.ack = 1'b0;
               else
                  nw = wd;
            tml_pkg::PC_LOCKHI:
               nw = {8'h00, cur[23:0] | wd[23:0]};
            tml_pkg::PC_CFG:
               if (s_r.mem[42][`TML_FRZ_BIT])
                  s_nxt.ack = 1'b0;
               else
               begin
                  nw = wd;
                  if (pg == `TML_PG_CFG0)
                  begin
                     nw[7:2] = 6'h00;
                     // mode kept unless retrieved or authenticated
                     if (I_SESSION == tml_pkg::TML_SES_ACTIVE)
                        nw[`TML_RID_BIT] = cur[`TML_RID_BIT];
                  end
               end
            tml_pkg::PC_KEYLOCK:
               if (cur[`TML_KEYBLK_BIT])
                  s_nxt.ack = 1'b0;
               else
                  nw = cur | {24'h000000, wd[7:5], 5'h00};
            tml_pkg::PC_KEY0:
               if (s_r.mem[45][`TML_KEY0_FRZ_BIT])
                  s_nxt.ack = 1'b0;
               else
                  nw = wd;
            tml_pkg::PC_KEY1:
               if (s_r.mem[45][`TML_KEY1_FRZ_BIT])
                  s_nxt.ack = 1'b0;
               else
                  nw = wd;
            tml_pkg::PC_RFU:
               nw = wd; // reserved pages kept as written
            tml_pkg::PC_BAD:
               s_nxt.ack = 1'b0;
         endcase
         if (read_restrict_select_hit)
            s_nxt.ack = 1'b0;
         s_nxt.nak = !s_nxt.ack;
         if (s_nxt.ack)
            s_nxt.mem[idx] = nw;
      end
      // signature masked in active random mode
      s_nxt.sig_mask = s_r.random_ident_enable
         && I_SESSION == tml_pkg::TML_SES_ACTIVE;
      // anticollision identifier and activation answers
      if (s_r.random_ident_enable)
      begin
         s_nxt.anti_id = {24'h000000, s_r.rid_val};
         s_nxt.anti_bcc = {8'h00, s_r.rid_val[7:0]
            ^ s_r.rid_val[15:8] ^ s_r.rid_val[23:16]
            ^ s_r.rid_val[31:24]};
         s_nxt.atqa = `TML_ATQA_4B;
      end
      else
      begin
         s_nxt.anti_id = {s_r.mem[1], s_r.mem[0][23:0]};
         s_nxt.anti_bcc = {s_r.mem[2][7:0], s_r.mem[0][31:24]};
         s_nxt.atqa = `TML_ATQA_7B;
      end
   end

   // state register; reset loads the factory image and defaults
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         s_r <= '0;
         s_r.mem <= mem_init();
         s_r.read_restrict_select_start <= `TML_READ_RESTRICT_SELECT_START_RST;
         s_r.anti_id <= P_UID;
         s_r.anti_bcc <= {BCC1, BCC0};
         s_r.atqa <= `TML_ATQA_7B;
      end
      else
         s_r <= s_nxt;
   end

   // outputs straight from state flops, except the constant O_SAK
   assign O_ACK = s_r.ack;
   assign O_NAK = s_r.nak;
   assign O_RDATA = s_r.rdata;
   assign O_SIG_MASK = s_r.sig_mask;
   assign O_RID_ACTIVE = s_r.random_ident_enable;
   assign O_ANTICOL_ID = s_r.anti_id;
   assign O_ANTICOL_BCC = s_r.anti_bcc;
   assign O_ATQA = s_r.atqa;
   assign O_SAK = `TML_SAK;
   assign O_SEC_MSG = s_r.mem[41][`TML_SEC_BIT];
   assign O_CNT_INC_OPEN = s_r.mem[42][`TML_INC_BIT];
   assign O_CNT_RD_OPEN = s_r.mem[42][`TML_RD_BIT];
   assign O_READ_RESTRICT = s_r.rd_restrict;
   assign O_READ_RESTRICT_SELECT_START = s_r.read_restrict_select_start;
   assign O_VIRT_TYPE = s_r.mem[42][15:8];
   assign O_FAIL_LIMIT = {s_r.mem[42][25:24], s_r.mem[42][23:16]};
   assign O_DATA_KEY = {s_r.mem[51], s_r.mem[50], s_r.mem[49],
      s_r.mem[48]};
   assign O_RETR_KEY = {s_r.mem[55], s_r.mem[54], s_r.mem[53],
      s_r.mem[52]};

   // checks of the documented behaviour
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B);

   sequence s_otp_wr;
      I_REQ && I_CMD.wr && I_CMD.page == `TML_PG_OTP
         && !s_r.mem[2][19] && !read_restrict_select_hit;
   endsequence
   sequence s_otp_done;
      O_ACK && s_r.mem[3] == ($past(s_r.mem[3]) | $past(I_CMD.wdata));
   endsequence

   AST_UID_RO: assert property (I_REQ && I_CMD.wr
      && I_CMD.page < `TML_PG_LOCKLO |=> O_NAK && !O_ACK)
      else $error("identifier page write not refused");
   AST_BYTE01_KEEP: assert property (##1 s_r.mem[2][15:0]
      == $past(s_r.mem[2][15:0]))
      else $error("page two bytes 0,1 changed");
   AST_LOCK_MONO: assert property (##1 ((s_r.mem[2][31:16]
      & $past(s_r.mem[2][31:16])) == $past(s_r.mem[2][31:16])
      && (s_r.mem[40] & $past(s_r.mem[40])) == $past(s_r.mem[40])))
      else $error("lock bit cleared");
   AST_OTP_OR: assert property (s_otp_wr |=> s_otp_done)
      else $error("one-time page not or'ed");
   AST_LOCKED_NAK: assert property (I_REQ && I_CMD.wr
      && pcls == tml_pkg::PC_LOWDATA && s_r.mem[2][{1'b1, pg[3:0]}]
      |=> O_NAK && !O_ACK ##0 s_r.mem == $past(s_r.mem))
      else $error("locked page write accepted");
   AST_MASK: assert property (I_REQ && !I_CMD.wr
      && I_CMD.page <= `TML_PG_LOCKLO && s_r.random_ident_enable && !read_restrict_select_hit
      && I_SESSION == tml_pkg::TML_SES_ACTIVE |=> O_ACK && O_RDATA == 0)
      else $error("identifier not masked");
   AST_HI_MSB: assert property (I_REQ && !I_CMD.wr
      && I_CMD.page == `TML_PG_LOCKHI && !read_restrict_select_hit
      |=> O_ACK && O_RDATA[31:24] == 8'h00)
      else $error("page 28 top byte not zero");
   AST_RID_IDLE: assert property ($changed(O_RID_ACTIVE)
      |-> $past(I_IDLE_ENTRY))
      else $error("random mode changed without idle entry");
   AST_RID_BCC: assert property (O_RID_ACTIVE ##1 O_RID_ACTIVE
      |-> O_ANTICOL_BCC[7:0] == (O_ANTICOL_ID[7:0] ^ O_ANTICOL_ID[15:8]
      ^ O_ANTICOL_ID[23:16] ^ O_ANTICOL_ID[31:24])
      && O_ATQA == `TML_ATQA_4B)
      else $error("random identifier check byte wrong");
   AST_KEY_FRZ: assert property (I_REQ && I_CMD.wr
      && pcls == tml_pkg::PC_KEY0 && s_r.mem[45][`TML_KEY0_FRZ_BIT]
      |=> O_NAK ##0 s_r.mem == $past(s_r.mem))
      else $error("frozen key written");
endmodule : tml_mem
`default_nettype wire

/* File: include/tml_consts.svh */
/*
 constants of the tag memory lock/config block: page addresses,
 bit positions, reset values, activation answers.
 assumes inclusion by bare name from the design file.
*/
`ifndef TML_CONSTS_SVH
`define TML_CONSTS_SVH
`define TML_CT 8'h88
`define TML_PG_LOCKLO 8'h02
`define TML_PG_OTP 8'h03
`define TML_PG_LOWDATA_LAST 8'h0F
`define TML_PG_HIDATA 8'h10
`define TML_PG_USER_LAST 8'h27
`define TML_PG_LOCKHI 8'h28
`define TML_PG_CFG0 8'h29
`define TML_PG_CFG1 8'h2A
`define TML_PG_KEYLOCK 8'h2D
`define TML_PG_KEY0 8'h30
`define TML_PG_KEY0_LAST 8'h33
`define TML_PG_KEY1 8'h34
`define TML_PG_KEY1_LAST 8'h37
`define TML_PG_LAST 8'h3B
`define TML_RID_BIT 0
`define TML_SEC_BIT 1
`define TML_INC_BIT 3
`define TML_RD_BIT 2
`define TML_FRZ_BIT 6
`define TML_READ_RESTRICT_SELECT_BIT 7
`define TML_KEYBLK_BIT 5
`define TML_KEY0_FRZ_BIT 6
`define TML_KEY1_FRZ_BIT 7
`define TML_READ_RESTRICT_SELECT_START_RST 8'h3C
`define TML_VIRTUAL_CARD_TYPE_RST 8'h05
`define TML_ATQA_7B 16'h0044
`define TML_ATQA_4B 16'h0004
`define TML_SAK 8'h00
`endif

/* File: include/tml_pkg.sv */
/*
 types of the tag memory lock/config block.
 assumes nothing beyond a SystemVerilog compiler.
*/
package tml_pkg;
   // session state given by the authentication block
   typedef enum logic [1:0] {
      TML_SES_ACTIVE,
      TML_SES_TRACEABLE,
      TML_SES_AUTH
   } tml_ses_t;
   // memory region classes of a page address
   typedef enum logic [3:0] {
      PC_UID, PC_LOCKLO, PC_OTP, PC_LOWDATA, PC_HIDATA, PC_LOCKHI,
      PC_CFG, PC_KEYLOCK, PC_KEY0, PC_KEY1, PC_RFU, PC_BAD
   } tml_pcls_t;
   // one page command from the protocol logic
   typedef struct packed {
      logic wr;
      logic [7:0] page;
      logic [31:0] wdata;
   } tml_req_t;
   // whole state of the block
   typedef struct packed {
      logic [59:0][31:0] mem;
      logic random_ident_enable;
      logic [7:0] read_restrict_select_start;
      logic rd_restrict;
      logic [31:0] rid_val;
      logic ack;
      logic nak;
      logic [31:0] rdata;
      logic sig_mask;
      logic [55:0] anti_id;
      logic [15:0] anti_bcc;
      logic [15:0] atqa;
   } tml_st_t;
endpackage : tml_pkg

/* File: tb/tml_reader.sv */
/*
 reader model: issues one page command per call on the tag's port.
 assumes the tag answers with ack or nak one cycle after the request.
*/
`timescale 1ns/1ps
`default_nettype none
module tml_reader (
   input wire logic i_clk,
   input wire logic i_ack,
   input wire logic i_nak,
   output var logic o_req,
   output var tml_pkg::tml_req_t o_cmd
);
   // idle at time zero, no command pending
   initial
   begin
      o_req = 1'h0;
      o_cmd = '0;
   end

   // one command; answer flags read once the answer edge has settled
   task automatic xfer(input logic wr, input logic [7:0] pg,
      input logic [31:0] d, output logic ack, output logic nak);
      @(posedge i_clk);
      o_req <= 1'h1;
      // reserved top byte of the high lock page is always sent as zero
      o_cmd <= '{wr, pg, (pg == 8'h28) ? {8'h00, d[23:0]} : d};
      @(posedge i_clk);
      o_req <= 1'h0;
      // released lines show junk so a stale command is never reused
      o_cmd <= ~o_cmd;
      #1;
      ack = i_ack;
      nak = i_nak;
   endtask : xfer
endmodule : tml_reader
`default_nettype wire

/* File: tb/tml_mem_bench.sv */
/*
 self-checking bench of the tag page memory, locks and configuration.
 assumes the reader model and the design's package and constants.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tml_consts.svh"
module tml_mem_bench;
   localparam logic [55:0] UID = 56'h11223344556677;
   localparam logic [7:0] B0 = 8'h88 ^ 8'h77 ^ 8'h66 ^ 8'h55;
   localparam logic [7:0] B1 = 8'h44 ^ 8'h33 ^ 8'h22 ^ 8'h11;
   localparam logic [31:0] P2 = {16'h0000, 8'hA5, B1};
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic idle = 1'h0;
   logic [31:0] rnd = 32'h0;
   tml_pkg::tml_ses_t ses = tml_pkg::TML_SES_ACTIVE;
   tml_pkg::tml_req_t cmd;
   logic req, ack, nak, sig, random_identifier, sec, inc, rdo, rr;
   logic [31:0] rdata;
   logic [55:0] aid;
   logic [15:0] bcc, atqa;
   logic [7:0] pst, vt, sak;
   logic [9:0] lim;
   logic [127:0] dk, rk;
   int n_mismatch = 0;
   int cmp_count = 0;

   // 200 MHz
   always #2.5 clk = ~clk;

   tml_reader u_rdr (.i_clk(clk), .i_ack(ack), .i_nak(nak),
      .o_req(req), .o_cmd(cmd));

   tml_mem #(.P_UID(UID), .P_INTERNAL(8'hA5)) u_dut (
      .I_CLK(clk), .I_RST_B(rst_b), .I_REQ(req), .I_CMD(cmd),
      .I_SESSION(ses), .I_IDLE_ENTRY(idle), .I_RAND_ID(rnd),
      .O_ACK(ack), .O_NAK(nak), .O_RDATA(rdata), .O_SIG_MASK(sig),
      .O_RID_ACTIVE(random_identifier), .O_ANTICOL_ID(aid), .O_ANTICOL_BCC(bcc),
      .O_ATQA(atqa), .O_SAK(sak), .O_SEC_MSG(sec), .O_CNT_INC_OPEN(inc),
      .O_CNT_RD_OPEN(rdo), .O_READ_RESTRICT(rr), .O_READ_RESTRICT_SELECT_START(pst),
      .O_VIRT_TYPE(vt), .O_FAIL_LIMIT(lim), .O_DATA_KEY(dk),
      .O_RETR_KEY(rk));

   // value compare, four-state exact
   task automatic chk(input string what, input logic [63:0] exp,
      input logic [63:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // page write, ok says whether an ack is due
   task automatic wr(input logic [7:0] p, input logic [31:0] d,
      input logic ok);
      logic a, n;
      u_rdr.xfer(1'h1, p, d, a, n);
      chk($sformatf("write %h", p), {ok, ~ok}, {a, n});
   endtask : wr

   // page read, data compared only when accepted
   task automatic rd(input logic [7:0] p, input logic ok,
      input logic [31:0] e);
      logic a, n;
      u_rdr.xfer(1'h0, p, 32'h0, a, n);
      chk($sformatf("read %h", p), {ok, ~ok}, {a, n});
      if (ok)
         chk($sformatf("data %h", p), e, rdata);
   endtask : rd

   // power-off-to-idle pulse; outputs settled two edges later
   task automatic go_idle(input logic [31:0] r);
      @(posedge clk);
      idle <= 1'h1;
      rnd <= r;
      @(posedge clk);
      idle <= 1'h0;
      @(posedge clk);
      #1;
   endtask : go_idle

   // session change, mask follows one cycle later
   task automatic set_ses(input tml_pkg::tml_ses_t s);
      @(posedge clk);
      ses <= s;
      @(posedge clk);
      @(posedge clk);
      #1;
   endtask : set_ses

   // verdict and end of run
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done

   // about 50 commands of 2 cycles; generous margin
   initial
   begin
      #(5 * 20000);
      n_mismatch++;
      test_done();
   end

   initial
   begin
      repeat (16) @(posedge clk);
      rst_b <= 1'h1;
      rd(8'h00, 1'h1, {B0, 8'h55, 8'h66, 8'h77});
      rd(8'h01, 1'h1, 32'h11223344);
      rd(8'h02, 1'h1, P2);
      rd(8'h03, 1'h1, 32'h0);
      rd(8'h28, 1'h1, 32'h0);
      chk("anticol id", UID, aid);
      chk("anticol bcc", {B1, B0}, bcc);
      chk("atqa", `TML_ATQA_7B, atqa);
      chk("sak", `TML_SAK, sak);
      $display("test reset done");
      wr(8'h00, 32'hFFFFFFFF, 1'h0);
      wr(8'h01, 32'h0, 1'h0);
      rd(8'h3C, 1'h0, 32'h0);
      wr(8'h03, 32'h000000F0, 1'h1);
      wr(8'h03, 32'h0F00000F, 1'h1);
      rd(8'h03, 1'h1, 32'h0F0000FF);
      $display("test identifier and one-time page done");
      // page 4 lock plus freeze of pages 4..9 lock bits
      wr(8'h02, 32'h0012FFFF, 1'h1);
      rd(8'h02, 1'h1, P2 | 32'h00120000);
      wr(8'h04, 32'h1, 1'h0);
      wr(8'h02, 32'h00200000, 1'h1);
      wr(8'h05, 32'hCAFE0005, 1'h1);
      rd(8'h05, 1'h1, 32'hCAFE0005);
      wr(8'h02, 32'h80000000, 1'h1);
      wr(8'h0F, 32'h1, 1'h0);
      $display("test low locks done");
      wr(8'h28, 32'h00000401, 1'h1);
      wr(8'h11, 32'h1, 1'h0);
      wr(8'h12, 32'h1, 1'h1);
      wr(8'h25, 32'h1, 1'h0);
      wr(8'h28, 32'h0, 1'h1);
      rd(8'h28, 1'h1, 32'h00000401);
      wr(8'h27, 32'h12345678, 1'h1);
      rd(8'h27, 1'h1, 32'h12345678);
      $display("test high locks done");
      wr(8'h29, 32'h3C000001, 1'h1);
      go_idle(32'h0);
      chk("rid in active", 1'h0, random_identifier);
      set_ses(tml_pkg::TML_SES_TRACEABLE);
      wr(8'h29, 32'h3C000003, 1'h1);
      chk("sec msg", 1'h1, sec);
      chk("rid early", 1'h0, random_identifier);
      go_idle(32'hA1B2C3D4);
      chk("rid on", 1'h1, random_identifier);
      chk("atqa rid", `TML_ATQA_4B, atqa);
      chk("rid id", {24'h0, 32'hA1B2C3D4}, aid);
      chk("rid bcc", {8'h00, 8'hA1 ^ 8'hB2 ^ 8'hC3 ^ 8'hD4}, bcc);
      chk("sig traceable", 1'h0, sig);
      rd(8'h00, 1'h1, {B0, 8'h55, 8'h66, 8'h77});
      set_ses(tml_pkg::TML_SES_ACTIVE);
      chk("sig active", 1'h1, sig);
      rd(8'h00, 1'h1, 32'h0);
      rd(8'h02, 1'h1, 32'h0);
      $display("test random id done");
      set_ses(tml_pkg::TML_SES_AUTH);
      wr(8'h29, 32'h20000003, 1'h1);
      chk("start early", 8'h3C, pst);
      wr(8'h2A, 32'h023407CC, 1'h1);
      chk("fail limit", 10'h234, lim);
      chk("virt type", 8'h07, vt);
      chk("cnt inc", 1'h1, inc);
      chk("cnt rd", 1'h1, rdo);
      chk("restrict early", 1'h0, rr);
      go_idle(32'h0);
      chk("start", 8'h20, pst);
      chk("restrict", 1'h1, rr);
      set_ses(tml_pkg::TML_SES_TRACEABLE);
      wr(8'h1F, 32'h0000001F, 1'h1);
      wr(8'h20, 32'h1, 1'h0);
      rd(8'h20, 1'h0, 32'h0);
      rd(8'h1F, 1'h1, 32'h0000001F);
      set_ses(tml_pkg::TML_SES_AUTH);
      wr(8'h29, 32'h3C000002, 1'h0);
      $display("test protection done");
      wr(8'h30, 32'h0BADF00D, 1'h1);
      chk("data key", 32'h0BADF00D, dk[31:0]);
      wr(8'h34, 32'h600DCAFE, 1'h1);
      chk("retr key", 32'h600DCAFE, rk[31:0]);
      wr(8'h2D, 32'h00000040, 1'h1);
      wr(8'h30, 32'h1, 1'h0);
      wr(8'h34, 32'h1, 1'h1);
      wr(8'h2D, 32'h00000020, 1'h1);
      wr(8'h2D, 32'h00000080, 1'h0);
      wr(8'h34, 32'h2, 1'h1);
      rd(8'h2D, 1'h1, 32'h00000060);
      rd(8'h30, 1'h1, 32'h0);
      $display("test key locks done");
      test_done();
   end
endmodule : tml_mem_bench
`default_nettype wire
